//--- logic/tpl_top.v
/*
 * T1 maintenance logic: framing bit error insertion, pseudo-random pattern
 * generator and detector, loopback code transmitter and two code detectors.
 * Assumes the framer supplies one-cycle bit strobes with F-bit position and
 * kind on the same clock, and software uses the strobed register port.
 */
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "tpl_defines.vh"

module tpl_top #(
    parameter PERIOD_CYC = (`TPL_LCD_PERIOD_US * 1000) / `TPL_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire       I_MCLK,
    input  wire       I_RST_N,
    // Register port
    input  wire [7:0] I_ADDR,
    input  wire [7:0] I_WDATA,
    input  wire       I_WR,
    input  wire       I_RD,
    output reg  [7:0] O_RDATA,
    // Transmit stream from the frame generator
    input  wire       I_TX_STB,
    input  wire       I_TX_DATA,
    input  wire       I_TX_FBIT,
    input  wire [1:0] I_TX_FKIND,
    input  wire       I_TX_MF_START,
    // Transmit stream to the line
    output reg        O_TX_STB,
    output reg        O_TX_DATA,
    // Receive stream from the line
    input  wire       I_RX_STB,
    input  wire       I_RX_DATA,
    input  wire       I_RX_FBIT,
    // Loopback code detector targets
    input  wire [7:0] I_ACT_CODE,
    input  wire [7:0] I_DEACT_CODE,
    // Status
    output wire       O_LOOP_ACT_DET,
    output wire       O_LOOP_DEACT_DET,
    output reg        O_INT_N
);
    localparam [22:0] PERIOD_LAST = PERIOD_CYC[22:0] - 23'h000001;

    // Feedback bit of the selected sequence; shared by generator and detector.
    function prbs_fb;
        input [19:0] s;
        input [1:0]  sel;
        begin
            case (sel)
                `TPL_PAT_15: prbs_fb = s[14] ^ s[13];
                `TPL_PAT_20: prbs_fb = s[19] ^ s[16];
                `TPL_PAT_11: prbs_fb = s[10] ^ s[8];
                default:     prbs_fb = s[14] ^ s[13];
            endcase
        end
    endfunction

    reg  [3:0]  fg_reg;
    reg  [2:0]  einv_reg;
    reg  [3:0]  pctl_reg;
    reg         ber_en_reg;
    reg         err_ins_reg;
    reg         sync_en_reg;
    reg         in_sync_reg;
    reg         ber_flag_reg;
    reg         sync_flag_reg;
    reg  [3:0]  lct_ctl_reg;
    reg  [7:0]  lct_code_reg;
    reg  [4:0]  lcd_cfg_reg;
    reg  [19:0] gen_reg;
    reg  [19:0] det_reg;
    reg  [2:0]  lc_idx_reg;
    reg         crc_run_reg;
    reg  [2:0]  crc_cnt_reg;
    reg  [5:0]  good_cnt_reg;
    reg  [5:0]  win_cnt_reg;
    reg  [3:0]  win_err_reg;
    reg  [22:0] period_reg;
    reg         tick_reg;
    reg         tx_bit_next;
    reg         ft_done;
    reg         fs_done;
    reg         crc_done;
    reg         ins_done;

    wire       frame_gen_disable      = fg_reg[`TPL_FG_DISABLE];
    wire [1:0] fmt       = fg_reg[2:1];
    wire       esf       = (fmt == `TPL_FMT_ESF);
    wire [1:0] pat_sel   = pctl_reg[1:0];
    wire       tx_pay    = I_TX_STB && !I_TX_FBIT;
    wire       gen_bit   = prbs_fb(gen_reg, pat_sel);
    wire       lc_en     = lct_ctl_reg[`TPL_LC_ENABLE];
    wire       lc_unfr   = lct_ctl_reg[`TPL_LC_UNFRAMED];
    wire       lc_use    = lc_en && I_TX_STB && (!I_TX_FBIT || lc_unfr);
    wire [2:0] lc_low    = {1'b0, 2'h3 - lct_ctl_reg[1:0]};
    wire       rx_pay    = I_RX_STB && !I_RX_FBIT;
    wire       rx_bit    = I_RX_DATA ^ pctl_reg[`TPL_PC_RX_INV];
    wire       det_err   = rx_bit ^ prbs_fb(det_reg, pat_sel);
    wire       f_ok      = I_TX_STB && I_TX_FBIT && !frame_gen_disable && !(lc_en && lc_unfr);
    wire       wr_fg     = I_WR && (I_ADDR == `TPL_ADDR_FRAME_GEN);
    wire       wr_ei     = I_WR && (I_ADDR == `TPL_ADDR_ERR_INSERT);
    wire       wr_pc     = I_WR && (I_ADDR == `TPL_ADDR_PRBS_CTRL);
    wire       wr_ps     = I_WR && (I_ADDR == `TPL_ADDR_PRBS_STAT);
    wire       wr_pf     = I_WR && (I_ADDR == `TPL_ADDR_PRBS_FLAGS);
    wire       wr_lc     = I_WR && (I_ADDR == `TPL_ADDR_LCT_CTRL);
    wire       wr_lk     = I_WR && (I_ADDR == `TPL_ADDR_LCT_CODE);
    wire       wr_ld     = I_WR && (I_ADDR == `TPL_ADDR_LCD_CFG);
    wire       crc_start = I_TX_STB && I_TX_MF_START && einv_reg[`TPL_EI_CRC]
                           && esf && !frame_gen_disable && !crc_run_reg;
    wire       crc_hit   = f_ok && esf && crc_run_reg && (I_TX_FKIND == `TPL_FK_CRC);
    wire       sync_set;
    wire       sync_clr;
    wire       ber_set   = rx_pay && in_sync_reg && det_err;

    // Transmit bit selection and one-shot error insertion on this strobe.
    always @* begin
        tx_bit_next = I_TX_DATA;
        ft_done     = 1'b0;
        fs_done     = 1'b0;
        crc_done    = 1'b0;
        ins_done    = 1'b0;
        if (tx_pay && fg_reg[`TPL_FG_PRBS_INSERT]) begin
            tx_bit_next = gen_bit ^ pctl_reg[`TPL_PC_TX_INV] ^ err_ins_reg;
            ins_done    = err_ins_reg;
        end
        if (lc_use) begin
            tx_bit_next = lct_code_reg[lc_idx_reg];
        end
        if (f_ok) begin
            if (I_TX_FKIND == `TPL_FK_ODD && !esf && einv_reg[`TPL_EI_FT]) begin
                tx_bit_next = ~I_TX_DATA;
                ft_done     = 1'b1;
            end
            // The even kind is an Fs bit in SF, DM and SLC-96, and the
            // alignment bit in ESF, so one test serves every format.
            if (I_TX_FKIND == `TPL_FK_EVEN && einv_reg[`TPL_EI_FS]) begin
                tx_bit_next = ~I_TX_DATA;
                fs_done     = 1'b1;
            end
            if (crc_hit) begin
                tx_bit_next = ~I_TX_DATA;
                crc_done    = (crc_cnt_reg == `TPL_CRC_GROUP_LAST);
            end
        end
    end

    // Transmit path, generator and loopback code sequencing.
    always @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_TX_STB    <= 1'b0;
            O_TX_DATA   <= 1'b0;
            gen_reg     <= 20'h00001;
            lc_idx_reg  <= 3'h7;
            crc_run_reg <= 1'b0;
            crc_cnt_reg <= 3'h0;
        end else begin
            O_TX_STB  <= I_TX_STB;
            O_TX_DATA <= I_TX_STB ? tx_bit_next : 1'b0;
            if (tx_pay) begin
                // An all-zero state would stall the sequence, so reseed it.
                if (gen_reg == 20'h00000) begin
                    gen_reg <= 20'h00001;
                end else begin
                    gen_reg <= {gen_reg[18:0], gen_bit};
                end
            end
            if (!lc_en) begin
                lc_idx_reg <= 3'h7;
            end else if (lc_use) begin
                if (lc_idx_reg <= lc_low) begin
                    lc_idx_reg <= 3'h7;
                end else begin
                    lc_idx_reg <= lc_idx_reg - 3'h1;
                end
            end
            if (crc_start) begin
                crc_run_reg <= 1'b1;
                crc_cnt_reg <= 3'h0;
            end else if (crc_hit) begin
                crc_cnt_reg <= crc_cnt_reg + 3'h1;
                if (crc_done) begin
                    crc_run_reg <= 1'b0;
                end
            end
        end
    end

    // Pattern detector synchronisation.
    assign sync_set = !in_sync_reg && rx_pay && !det_err
                      && (good_cnt_reg == `TPL_SYNC_GOOD_BITS - 6'h01);
    assign sync_clr = in_sync_reg && rx_pay && det_err
                      && (win_err_reg == `TPL_SYNC_LOSS_ERRS - 4'h1);

    always @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            det_reg      <= 20'h00000;
            in_sync_reg  <= 1'b0;
            good_cnt_reg <= 6'h00;
            win_cnt_reg  <= 6'h00;
            win_err_reg  <= 4'h0;
        end else if (rx_pay) begin
            det_reg <= {det_reg[18:0], rx_bit};
            if (sync_set) begin
                in_sync_reg <= 1'b1;
                win_cnt_reg <= 6'h00;
                win_err_reg <= 4'h0;
            end else if (sync_clr) begin
                in_sync_reg  <= 1'b0;
                good_cnt_reg <= 6'h00;
            end else if (in_sync_reg) begin
                if (win_cnt_reg == `TPL_SYNC_WINDOW_LAST) begin
                    win_cnt_reg <= 6'h00;
                    win_err_reg <= 4'h0;
                end else begin
                    win_cnt_reg <= win_cnt_reg + 6'h01;
                    win_err_reg <= win_err_reg + {3'h0, det_err};
                end
            end else begin
                good_cnt_reg <= det_err ? 6'h00 : good_cnt_reg + 6'h01;
            end
        end
    end

    // Loopback code detectors share one observation period divider.
    always @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            period_reg <= 23'h000000;
            tick_reg   <= 1'b0;
        end else begin
            tick_reg <= (period_reg == PERIOD_LAST);
            if (period_reg == PERIOD_LAST) begin
                period_reg <= 23'h000000;
            end else begin
                period_reg <= period_reg + 23'h000001;
            end
        end
    end

    tpl_lcd u_act (
        .clk      (I_MCLK),
        .rst_n    (I_RST_N),
        .i_code   (I_ACT_CODE),
        .i_len    (lcd_cfg_reg[1:0]),
        .i_skip_f (lcd_cfg_reg[4]),
        .i_stb    (I_RX_STB),
        .i_data   (I_RX_DATA),
        .i_fbit   (I_RX_FBIT),
        .i_tick   (tick_reg),
        .o_det    (O_LOOP_ACT_DET)
    );

    tpl_lcd u_deact (
        .clk      (I_MCLK),
        .rst_n    (I_RST_N),
        .i_code   (I_DEACT_CODE),
        .i_len    (lcd_cfg_reg[3:2]),
        .i_skip_f (lcd_cfg_reg[4]),
        .i_stb    (I_RX_STB),
        .i_data   (I_RX_DATA),
        .i_fbit   (I_RX_FBIT),
        .i_tick   (tick_reg),
        .o_det    (O_LOOP_DEACT_DET)
    );

    // Register file. Self-clearing bits drop when their action completes;
    // a write in the same cycle is applied on top of that clear.
    always @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            fg_reg        <= `TPL_FG_RESET;
            einv_reg      <= 3'h0;
            pctl_reg      <= 4'h0;
            ber_en_reg    <= 1'b0;
            err_ins_reg   <= 1'b0;
            sync_en_reg   <= 1'b0;
            ber_flag_reg  <= 1'b0;
            sync_flag_reg <= 1'b0;
            lct_ctl_reg   <= 4'h0;
            lct_code_reg  <= `TPL_LCT_CODE_RESET;
            lcd_cfg_reg   <= `TPL_LCD_CFG_RESET;
            O_INT_N       <= 1'b1;
        end else begin
            if (wr_fg) begin
                fg_reg <= I_WDATA[3:0];
            end
            if (wr_ei) begin
                einv_reg <= I_WDATA[2:0];
            end else begin
                einv_reg <= einv_reg & ~{crc_done, fs_done, ft_done};
            end
            if (wr_pc) begin
                pctl_reg <= I_WDATA[3:0];
            end
            if (wr_ps) begin
                ber_en_reg  <= I_WDATA[`TPL_PS_BER_EN];
                err_ins_reg <= I_WDATA[`TPL_PS_ERR_INS];
                sync_en_reg <= I_WDATA[`TPL_PS_SYNC_EN];
            end else if (ins_done) begin
                err_ins_reg <= 1'b0;
            end
            // A new event in the clearing cycle keeps its flag set.
            ber_flag_reg  <= ber_set | (ber_flag_reg &
                             ~(wr_pf & I_WDATA[`TPL_PF_BIT_ERR]));
            sync_flag_reg <= sync_set | sync_clr | (sync_flag_reg &
                             ~(wr_pf & I_WDATA[`TPL_PF_SYNC_CHG]));
            if (wr_lc) begin
                lct_ctl_reg <= I_WDATA[3:0];
            end
            if (wr_lk) begin
                lct_code_reg <= I_WDATA;
            end
            if (wr_ld) begin
                lcd_cfg_reg <= I_WDATA[4:0];
            end
            O_INT_N <= ~((ber_flag_reg & ber_en_reg) |
                         (sync_flag_reg & sync_en_reg));
        end
    end

    // Read data stands in the cycle after the read strobe only.
    always @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_RDATA <= 8'h00;
        end else if (I_RD) begin
            case (I_ADDR)
                `TPL_ADDR_FRAME_GEN:  O_RDATA <= {4'h0, fg_reg};
                `TPL_ADDR_ERR_INSERT: O_RDATA <= {5'h00, einv_reg};
                `TPL_ADDR_PRBS_CTRL:  O_RDATA <= {4'h0, pctl_reg};
                `TPL_ADDR_PRBS_STAT:  O_RDATA <= {4'h0, ber_en_reg, err_ins_reg,
                                                  in_sync_reg, sync_en_reg};
                `TPL_ADDR_PRBS_FLAGS: O_RDATA <= {4'h0, ber_flag_reg, 2'h0, sync_flag_reg};
                `TPL_ADDR_LCT_CTRL:   O_RDATA <= {4'h0, lct_ctl_reg};
                `TPL_ADDR_LCT_CODE:   O_RDATA <= lct_code_reg;
                `TPL_ADDR_LCD_CFG:    O_RDATA <= {3'h0, lcd_cfg_reg};
                default:              O_RDATA <= 8'h00;
            endcase
        end else begin
            O_RDATA <= 8'h00;
        end
    end
endmodule // tpl_top

//--- logic/tpl_defines.vh
/*
 * Constants of the T1 test pattern and loopback code block: register offsets,
 * field positions, reset values, encodings and timing counts.
 * Assumes a single 200 MHz clock and byte-wide register access.
 */
// Summary of operation
// - ESF CRC invert flips one 6-bit group
// - CRC invert only ESF with framing enabled
// - SF/DM Fs invert flips one even F-bit
// - ESF Fs invert flips one alignment bit
// - SLC-96 Fs invert flips one sync bit
// - Ft invert flips one odd F-bit
// - Generator invert complements sent pattern
// - Receive invert complements detector input
// - Pattern select picks 15, 20, 11 sequence
// - Single error insert corrupts one bit
// - Ten errors in 48 bits lose sync
// - 48 error-free bits declare sync
// - In-sync mismatch sets sticky error flag
// - Sync change sets sticky change flag
// - Interrupt low only for enabled flags
// - Loop code sent only when enabled
// - Framed mode overwrites channels, keeps F-bit
// - Unframed mode overwrites channels and F-bits
// - Length field gives 5 to 8 bits
// - Code taken from bit 7 downward
// - F-bit skip or compare and discard
// - Detector target lengths from own fields
// - Framing disable blocks framing error insertion
// - 127 good periods detect, over 600 errors lose
// - Target MSB compared against first bit
`ifndef TPL_DEFINES_VH
`define TPL_DEFINES_VH

`define TPL_ADDR_FRAME_GEN    8'h62
`define TPL_ADDR_ERR_INSERT   8'h6F
`define TPL_ADDR_PRBS_CTRL    8'h71
`define TPL_ADDR_PRBS_STAT    8'h72
`define TPL_ADDR_PRBS_FLAGS   8'h73
`define TPL_ADDR_LCT_CTRL     8'h74
`define TPL_ADDR_LCT_CODE     8'h75
`define TPL_ADDR_LCD_CFG      8'h76

`define TPL_FG_DISABLE        0
`define TPL_FG_PRBS_INSERT    3
`define TPL_EI_FT             0
`define TPL_EI_FS             1
`define TPL_EI_CRC            2
`define TPL_PC_RX_INV         3
`define TPL_PC_TX_INV         2
`define TPL_PS_BER_EN         3
`define TPL_PS_ERR_INS        2
`define TPL_PS_IN_SYNC        1
`define TPL_PS_SYNC_EN        0
`define TPL_PF_BIT_ERR        3
`define TPL_PF_SYNC_CHG       0
`define TPL_LC_ENABLE         3
`define TPL_LC_UNFRAMED       2

`define TPL_FG_RESET          4'h0
`define TPL_LCT_CODE_RESET    8'h00
`define TPL_LCD_CFG_RESET     5'h04

`define TPL_FMT_SF            2'h0
`define TPL_FMT_ESF           2'h1
`define TPL_FMT_DM            2'h2
`define TPL_FMT_SLC           2'h3

`define TPL_FK_ODD            2'h0
`define TPL_FK_EVEN           2'h1
`define TPL_FK_CRC            2'h2
`define TPL_FK_OTHER          2'h3

`define TPL_PAT_15            2'h0
`define TPL_PAT_20            2'h1
`define TPL_PAT_11            2'h2

`define TPL_CRC_GROUP_LAST    3'h5
`define TPL_SYNC_WINDOW_LAST  6'h2F
`define TPL_SYNC_LOSS_ERRS    4'hA
`define TPL_SYNC_GOOD_BITS    6'h30

`define TPL_LCD_PERIOD_US     39800
`define TPL_CLK_PERIOD_NS     5
`define TPL_LCD_LOSS_LIMIT    10'h258
`define TPL_LCD_GOOD_PERIODS  7'h7E

`endif

//--- logic/tpl_lcd.v
/*
 * One loopback code detector: compares received bits with a target code and
 * judges the code present or lost once per observation period.
 * Assumes bit strobes and the period tick come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "tpl_defines.vh"

module tpl_lcd (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Configuration
    input  wire [7:0] i_code,
    input  wire [1:0] i_len,
    input  wire       i_skip_f,
    // Received line bits
    input  wire       i_stb,
    input  wire       i_data,
    input  wire       i_fbit,
    // Period tick and result
    input  wire       i_tick,
    output reg        o_det
);
    reg  [7:0] hist_reg;
    reg  [2:0] phase_reg;
    reg  [9:0] err_reg;
    reg  [6:0] good_reg;
    wire [2:0] low      = {1'b0, 2'h3 - i_len};
    wire [7:0] mask     = 8'hFF >> low;
    wire       use_bit  = i_stb && !(i_fbit && i_skip_f);
    wire       count_it = use_bit && !i_fbit;
    wire [7:0] hist_new = {hist_reg[6:0], i_data};
    wire       aligned  = ((hist_new ^ (i_code >> low)) & mask) == 8'h00;
    wire       miss     = count_it && (i_data != i_code[phase_reg]);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_reg  <= 8'h00;
            phase_reg <= 3'h7;
            err_reg   <= 10'h000;
            good_reg  <= 7'h00;
            o_det     <= 1'b0;
        end else begin
            if (use_bit) begin
                hist_reg <= hist_new;
                // A full code seen in the history realigns so the MSB is next.
                if (aligned || phase_reg <= low) begin
                    phase_reg <= 3'h7;
                end else begin
                    phase_reg <= phase_reg - 3'h1;
                end
            end
            if (i_tick) begin
                err_reg <= {9'h000, miss};
                if (err_reg > `TPL_LCD_LOSS_LIMIT) begin
                    good_reg <= 7'h00;
                    o_det    <= 1'b0;
                end else if (err_reg < `TPL_LCD_LOSS_LIMIT) begin
                    if (good_reg != 7'h7F) begin
                        good_reg <= good_reg + 7'h01;
                    end
                    if (good_reg >= `TPL_LCD_GOOD_PERIODS) begin
                        o_det <= 1'b1;
                    end
                end else begin
                    good_reg <= 7'h00;
                end
            end else if (miss && err_reg != 10'h3FF) begin
                err_reg <= err_reg + 10'h001;
            end
        end
    end
endmodule // tpl_lcd

//--- sim/tpl_asserts.sv
/* Checker of tpl_top: register read-back, stream pass-through and interrupt masking.
   Assumes it sees register writes at the ports exactly as the block takes them. */
`timescale 1ns/1ps
module tpl_asserts (
    // Clock, reset and register port
    input wire       I_MCLK, I_RST_N, I_WR, I_RD,
    input wire [7:0] I_ADDR, I_WDATA, O_RDATA,
    // Streams and interrupt
    input wire       I_TX_STB, I_TX_DATA, I_TX_FBIT, O_TX_STB, O_TX_DATA, O_INT_N
);
    reg [7:0] code_reg;
    reg [3:0] lc_reg;
    reg [4:0] cfg_reg;
    reg [1:0] fg_reg, en_reg;
    always @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            {code_reg, lc_reg, cfg_reg, fg_reg, en_reg} <= {8'h00, 4'h0, 5'h04, 4'h0};
        end else if (I_WR) begin
            case (I_ADDR)
                8'h62: fg_reg <= {I_WDATA[3], I_WDATA[0]};
                8'h72: en_reg <= {I_WDATA[3], I_WDATA[0]};
                8'h74: lc_reg <= I_WDATA[3:0];
                8'h75: code_reg <= I_WDATA;
                8'h76: cfg_reg <= I_WDATA[4:0];
                default: ;
            endcase
        end
    end
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);
    sequence rd_s(a);
        I_RD && I_ADDR == a;
    endsequence
    code_read_a: assert property (rd_s(8'h75) |=> O_RDATA == $past(code_reg))
        else $error("loop code read-back wrong");
    len_read_a: assert property (rd_s(8'h74) |=> O_RDATA == {4'h0, $past(lc_reg)})
        else $error("loop control read-back wrong");
    cfg_read_a: assert property (rd_s(8'h76) |=> O_RDATA == {3'h0, $past(cfg_reg)})
        else $error("detector config read-back wrong");
    irq_en_read_a: assert property (rd_s(8'h72) |=> {O_RDATA[3], O_RDATA[0]} == $past(en_reg))
        else $error("enable bits read-back wrong");
    stb_follow_a: assert property (I_TX_STB ##1 !I_TX_STB |-> O_TX_STB ##1 !O_TX_STB)
        else $error("output strobe not one cycle behind");
    pass_thru_a: assert property (I_TX_STB && fg_reg == 2'b01 && !lc_reg[3]
        |=> O_TX_DATA == $past(I_TX_DATA)) else $error("idle stream altered");
    framed_code_a: assert property (I_TX_STB && !I_TX_FBIT && lc_reg[3] && code_reg == 8'hFF
        |=> O_TX_DATA) else $error("channel bit not overwritten");
    int_mask_a: assert property (!O_INT_N |-> $past(en_reg) != 2'b00)
        else $error("interrupt without enable");
endmodule // tpl_asserts
bind tpl_top tpl_asserts chk_u (.*);

//--- sim/tpl_line_model.sv
/* Remote line equipment: loops the transmitted line back into the receiver.
   Assumes bit strobes on the block clock; F-bit marks come from the bench. */
`timescale 1ns/1ps
module tpl_line_model (
    // Line from the block
    input  wire clk,
    input  wire i_stb,
    input  wire i_data,
    input  wire i_fbit,
    // Line into the block
    output reg  o_stb = 1'b0,
    output reg  o_data = 1'b0,
    output reg  o_fbit = 1'b0
);
    reg fbit_reg = 1'b0;
    // Between bits the line holds nothing valid, so it toggles to expose stale sampling.
    always @(posedge clk) begin
        fbit_reg <= i_fbit;
        o_stb    <= i_stb;
        o_data   <= i_stb ? i_data : ~o_data;
        o_fbit   <= fbit_reg;
    end
endmodule // tpl_line_model

//--- sim/tpl_top_tb.sv
/* Testbench of tpl_top: registers, loop code, F-bit errors and test pattern.
   Assumes the line model loops the line back and the checker is bound. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin miscompares++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tpl_top_tb;
    reg         clk = 0, rst_n = 0, wr = 0, rd = 0, rd_d = 0;
    reg         tstb = 0, tdat = 0, tfb = 0, mfs = 0;
    reg  [7:0]  adr = 0, wd = 0, c, rx;
    reg  [1:0]  tk = 0, e;
    wire [7:0]  rdat;
    wire        ostb, odat, rstb, rdt, rfb, intn, adet, ddet;
    int         checks = 0, miscompares = 0, cyc = 0, i, j, n;
    logic [1:0] q[$];
    logic [7:0] rq[$];
    logic [1:0] fmt_t[5] = '{0, 0, 1, 3, 1};
    logic [1:0] fk_t[5] = '{1, 0, 1, 1, 2};
    logic [7:0] ei_t[5] = '{2, 1, 2, 2, 4};
    int         cnt_t[5] = '{1, 1, 1, 1, 6};
    tpl_top #(.PERIOD_CYC(200)) dut_u (.I_MCLK(clk), .I_RST_N(rst_n), .I_ADDR(adr),
        .I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdat), .I_TX_STB(tstb), .I_TX_DATA(tdat),
        .I_TX_FBIT(tfb), .I_TX_FKIND(tk), .I_TX_MF_START(mfs), .O_TX_STB(ostb),
        .O_TX_DATA(odat), .I_RX_STB(rstb), .I_RX_DATA(rdt), .I_RX_FBIT(rfb),
        .I_ACT_CODE(8'h08), .I_DEACT_CODE(8'h24), .O_LOOP_ACT_DET(adet), .O_LOOP_DEACT_DET(ddet),
        .O_INT_N(intn));
    tpl_line_model line_u (.clk(clk), .i_stb(ostb), .i_data(odat), .i_fbit(tfb),
        .o_stb(rstb), .o_data(rdt), .o_fbit(rfb));
    initial forever #2.5 clk = ~clk;
    task results;
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        rd_d <= rd;
        cyc <= cyc + 1;
        if (cyc > 30000) begin
            miscompares++;
            results();
        end
    end
    // Results are taken at the falling edge, well clear of the launching edge.
    always @(negedge clk) begin
        if (rd_d) begin
            rx = rq.pop_front();
            `CHK("rdata", rx, rdat)
        end
        if (ostb) begin
            e = q.pop_front();
            if (e[1]) `CHK("tx_data", e[0], odat)
        end
    end
    task wreg(input [7:0] a, d);
        @(posedge clk);
        {wr, adr, wd} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 0;
    endtask
    task rreg(input [7:0] a, x);
        rq.push_back(x);
        @(posedge clk);
        {rd, adr} <= {1'b1, a};
        @(posedge clk);
        rd <= 0;
    endtask
    task tbit(input d, f, m, input [1:0] k, x);
        q.push_back(x);
        @(posedge clk);
        {tstb, tdat, tfb, mfs, tk} <= {1'b1, d, f, m, k};
        @(posedge clk);
        tstb <= 0;
    endtask
    task prbs(input int b);
        repeat (b) tbit(1'($urandom), 0, 0, 0, 0);
    endtask
    initial begin
        void'($urandom(21));
        repeat (12) @(posedge clk);
        rst_n <= 1;
        rreg(8'h75, 8'h00);
        rreg(8'h76, 8'h04);
        rreg(8'h50, 8'h00);
        c = $urandom;
        wreg(8'h71, c);
        rreg(8'h71, {4'h0, c[3:0]});
        wreg(8'h62, 8'h01);
        // Every invert request pending while framing is off must leave the F-bits alone.
        wreg(8'h6F, 8'h07);
        repeat (8) begin
            c = $urandom;
            tbit(c[0], c[1], 0, c[3:2], {1'b1, c[0]});
        end
        rreg(8'h6F, 8'h07);
        for (i = 0; i < 4; i++) begin
            c = $urandom;
            n = 5 + i;
            wreg(8'h75, c);
            wreg(8'h74, 8'h0C | i[7:0]);
            rreg(8'h74, 8'h0C | i[7:0]);
            for (j = 0; j < 3 * n; j++)
                tbit(1'($urandom), j % 4 == 0, 0, 0, {1'b1, c[7 - j % n]});
            wreg(8'h74, 8'h00);
        end
        wreg(8'h75, 8'hFF);
        wreg(8'h74, 8'h0B);
        for (j = 0; j < 12; j++) begin
            c = $urandom;
            tbit(c[0], j % 3 == 0, 0, 0, {1'b1, c[0] | (j % 3 != 0)});
        end
        wreg(8'h74, 8'h00);
        for (i = 0; i < 5; i++) begin
            wreg(8'h62, {5'h0, fmt_t[i], 1'b0});
            wreg(8'h6F, ei_t[i]);
            for (j = 0; j < 16; j++) begin
                c = $urandom;
                tbit(c[0], j[0], j == 0, fk_t[i], {1'b1, c[0] ^ (j[0] && j / 2 < cnt_t[i])});
            end
            rreg(8'h6F, 8'h00);
        end
        wreg(8'h62, 8'h09);
        wreg(8'h72, 8'h09);
        // Receive invert drops any chance lock taken on earlier traffic, so the
        // flags below start from a known out-of-sync detector.
        wreg(8'h71, 8'h08);
        prbs(60);
        wreg(8'h73, 8'hFF);
        for (i = 0; i < 3; i++) begin
            wreg(8'h71, i[7:0]);
            prbs(200);
            rreg(8'h72, 8'h0B);
            rreg(8'h73, 8'h01);
            @(negedge clk);
            `CHK("int_n", 1'b0, intn)
        end
        wreg(8'h73, 8'hFF);
        prbs(60);
        rreg(8'h73, 8'h00);
        @(negedge clk);
        `CHK("int_n", 1'b1, intn)
        wreg(8'h72, 8'h0D);
        prbs(20);
        rreg(8'h72, 8'h0B);
        rreg(8'h73, 8'h08);
        wreg(8'h72, 8'h00);
        prbs(2);
        @(negedge clk);
        `CHK("int_n", 1'b1, intn)
        wreg(8'h73, 8'hFF);
        wreg(8'h71, 8'h08);
        prbs(100);
        rreg(8'h72, 8'h00);
        wreg(8'h71, 8'h0C);
        prbs(200);
        rreg(8'h72, 8'h02);
        @(negedge clk);
        `CHK("act_det", 1'b0, adet)
        `CHK("deact_det", 1'b0, ddet)
        // A short period holds far fewer than 600 bits, so every period counts as good.
        wait (cyc == 26000);
        @(negedge clk);
        `CHK("act_det", 1'b1, adet)
        `CHK("deact_det", 1'b1, ddet)
        results();
    end
endmodule // tpl_top_tb
